/* File: design/svdc_pkg.sv */
package svdc_pkg;
    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_CONTROL = 12'h000;  // voltage_detect_control
    localparam logic [11:0] ADDR_STATUS  = 12'h004;  // sticky event status, read clears
    localparam logic [11:0] ADDR_MASK    = 12'h008;  // interrupt mask
    localparam logic [11:0] ADDR_PINS    = 12'h00C;  // live comparator and stage state

    // ------------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------------
    localparam int unsigned POS_DIR    = 7;  // trip_direction_select
    localparam int unsigned POS_STABLE = 5;  // reference_stable_flag, read only
    localparam int unsigned POS_EN     = 4;  // detector_enable
    localparam logic [3:0]  LEVEL_EXTERNAL = 4'hF;  // route external_trip_input

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  RESET_CONTROL = 8'h00;
    localparam logic [1:0]  RESET_STATUS  = 2'h0;
    localparam logic [1:0]  RESET_MASK    = 2'h0;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ   = 25_000_000;
    localparam int unsigned SETTLE_TIME_US = 20;  // settling after each enable
    localparam int unsigned SETTLE_CYCLES =
        (SETTLE_TIME_US * (CLK_FREQ_HZ / 1_000_000) > 0) ?
        SETTLE_TIME_US * (CLK_FREQ_HZ / 1_000_000) : 1;
    localparam int unsigned SETTLE_W = 10;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       trip_direction_select;  // 1 = rising trip
        logic       detector_enable;
        logic [3:0] trip_level_select;
    } svdc_ctrl_t;

    typedef struct packed {
        logic       sel;    // address phase accepted
        logic       write;
        logic [11:0] addr;
    } svdc_bus_req_t;
endpackage : svdc_pkg

/* File: design/svdc_sync2.sv */
`timescale 1ns/100ps
// two flop synchroniser for one asynchronous level
module svdc_sync2 (
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // level in and out
    input  wire logic din,
    output logic      dout
);
    logic meta_r;  // first stage, read only by second stage

    // ------------------------------------------------------------------
    // two stages
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_r <= 1'b0;
            dout   <= 1'b0;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule : svdc_sync2

/* File: design/svdc_settle.sv */
`timescale 1ns/100ps
// settling timer, restarts on each enable
module svdc_settle (
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // control and status
    input  wire logic enable,
    output logic      stable
);
    logic [svdc_pkg::SETTLE_W-1:0] cnt_r;  // cycles since enable

    // ------------------------------------------------------------------
    // count while enabled, clear when off
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r  <= '0;
            stable <= 1'b0;
        end else if (!enable) begin
            cnt_r  <= '0;  // off: restart next time
            stable <= 1'b0;
        end else if (cnt_r == svdc_pkg::SETTLE_W'(svdc_pkg::SETTLE_CYCLES - 1)) begin
            stable <= 1'b1;  // settled
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
endmodule : svdc_settle

/* File: design/svdc_top.sv */
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
// Functional notes
// - enable bit 4 turns detector on
// - read-only stable bit 5 after settling
// - no interrupt before stable is set
// - bit 7 picks falling or rising trip
// - bits 3:0 pick one of sixteen levels
// - level all ones selects external input
// - comparator trip sets event flag
module svdc_top (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // analogue side
    input  wire logic        comp_out,
    output logic             detector_on,
    output logic             ext_input_route,
    output logic      [3:0]  tap_select,
    output logic             direction_rise,
    // interrupt
    output logic             irq
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    svdc_pkg::svdc_ctrl_t    ctrl_r;      // software control fields
    svdc_pkg::svdc_bus_req_t req_r;       // latched address phase
    logic [1:0]              status_r;    // [0] trip event, [1] stable reached
    logic [1:0]              mask_r;      // interrupt mask, same layout
    logic                    stable;      // settling done
    logic                    stable_d_r;  // previous stable
    logic                    comp_sync;   // synchronised comparator
    logic                    comp_d_r;    // previous qualified trip level
    logic                    trip_now;    // comparator says tripped
    logic                    trip_edge;   // entry into tripped state
    logic                    ctrl_wr;     // control write in data phase
    logic                    rd_take;     // read accepted in address phase
    logic                    stat_rd;     // status read accepted, clears status
    logic [31:0]             rdata_nxt;   // read mux

    // ------------------------------------------------------------------
    // comparator synchroniser
    // ------------------------------------------------------------------
    svdc_sync2 u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .din     (comp_out),
        .dout    (comp_sync)
    );

    // ------------------------------------------------------------------
    // settling timer
    // ------------------------------------------------------------------
    svdc_settle u_settle (
        .hclk    (hclk),
        .hresetn (hresetn),
        .enable  (ctrl_r.detector_enable),
        .stable  (stable)
    );

    // ------------------------------------------------------------------
    // settling checks
    // ------------------------------------------------------------------
    // switching off drops stable at the next edge
    a_stable_clears_off : assert property (
        @(posedge hclk) disable iff (!hresetn)
        !ctrl_r.detector_enable
        |=> !stable)
        else $error("stable held while detector off");

    // a fresh enable never reads stable at once
    a_stable_waits : assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(ctrl_r.detector_enable)
        |=> (!stable) [*8])
        else $error("stable set too soon after enable");

    // ------------------------------------------------------------------
    // ahb address phase capture
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_r <= '0;
        end else if (hready) begin
            req_r.sel   <= hsel && htrans[1];  // nonseq or seq
            req_r.write <= hwrite;
            req_r.addr  <= haddr[11:0];
        end
    end

    // always ready, always okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // control and mask writes
    // ------------------------------------------------------------------
    // write to control lands at the end of its data phase
    assign ctrl_wr = req_r.sel && req_r.write && req_r.addr == svdc_pkg::ADDR_CONTROL;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r.trip_direction_select <= svdc_pkg::RESET_CONTROL[svdc_pkg::POS_DIR];
            ctrl_r.detector_enable       <= svdc_pkg::RESET_CONTROL[svdc_pkg::POS_EN];
            ctrl_r.trip_level_select     <= svdc_pkg::RESET_CONTROL[3:0];
        end else if (ctrl_wr) begin
            ctrl_r.trip_direction_select <= hwdata[svdc_pkg::POS_DIR];
            ctrl_r.detector_enable       <= hwdata[svdc_pkg::POS_EN];
            ctrl_r.trip_level_select     <= hwdata[3:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_r <= svdc_pkg::RESET_MASK;
        end else if (req_r.sel && req_r.write && req_r.addr == svdc_pkg::ADDR_MASK) begin
            mask_r <= hwdata[1:0];
        end
    end

    // ------------------------------------------------------------------
    // analogue control outputs
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            detector_on     <= 1'b0;
            ext_input_route <= 1'b0;
            tap_select      <= 4'h0;
            direction_rise  <= 1'b0;
        end else begin
            detector_on     <= ctrl_r.detector_enable;
            ext_input_route <= ctrl_r.trip_level_select == svdc_pkg::LEVEL_EXTERNAL;
            tap_select      <= ctrl_r.trip_level_select;
            direction_rise  <= ctrl_r.trip_direction_select;
        end
    end

    // ------------------------------------------------------------------
    // control path checks, two edges from write to output
    // ------------------------------------------------------------------
    // enable bit written reaches the detector
    a_enable_to_on : assert property (
        @(posedge hclk) disable iff (!hresetn)
        ctrl_wr
        |-> ##2 (detector_on == $past(hwdata[svdc_pkg::POS_EN], 2)))
        else $error("detector_on does not follow enable write");

    // direction bit written reaches the comparator side
    a_dir_to_rise : assert property (
        @(posedge hclk) disable iff (!hresetn)
        ctrl_wr
        |-> ##2 (direction_rise == $past(hwdata[svdc_pkg::POS_DIR], 2)))
        else $error("direction_rise does not follow direction write");

    // level field written reaches the tap select
    a_level_to_tap : assert property (
        @(posedge hclk) disable iff (!hresetn)
        ctrl_wr
        |-> ##2 (tap_select == $past(hwdata[3:0], 2)))
        else $error("tap_select does not follow level write");

    // all ones level routes the external input
    a_all_ones_ext : assert property (
        @(posedge hclk) disable iff (!hresetn)
        ctrl_wr
        |-> ##2 (ext_input_route == ($past(hwdata[3:0], 2) == svdc_pkg::LEVEL_EXTERNAL)))
        else $error("external route does not follow level write");

    // ------------------------------------------------------------------
    // trip detection
    // ------------------------------------------------------------------
    // comparator high means supply above set point, whichever sense is chosen;
    // a falling trip is the comparator's low side, a rising trip its high
    assign trip_now  = ctrl_r.trip_direction_select ? comp_sync : !comp_sync;
    assign trip_edge = trip_now && !comp_d_r;

    // remember last qualified trip level; forced idle until stable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            comp_d_r   <= 1'b0;
            stable_d_r <= 1'b0;
        end else begin
            comp_d_r   <= trip_now && stable && ctrl_r.detector_enable;
            stable_d_r <= stable;
        end
    end

    // ------------------------------------------------------------------
    // sticky status, cleared by read, set wins over clear
    // ------------------------------------------------------------------
    // read taken in its address phase, so data and clear share one edge
    assign rd_take = hready && hsel && htrans[1] && !hwrite;
    assign stat_rd = rd_take && haddr[11:0] == svdc_pkg::ADDR_STATUS;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_r <= svdc_pkg::RESET_STATUS;
        end else begin
            // event only when enabled and settled; disabling sets nothing
            status_r[0] <= (trip_edge && stable && ctrl_r.detector_enable)
                           || (status_r[0] && !stat_rd);
            status_r[1] <= (stable && !stable_d_r) || (status_r[1] && !stat_rd);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_r & mask_r);
        end
    end

    // ------------------------------------------------------------------
    // event checks
    // ------------------------------------------------------------------
    // nothing is flagged while settling
    a_no_flag_unstable : assert property (
        @(posedge hclk) disable iff (!hresetn)
        !stable
        |=> !$rose(status_r[0]))
        else $error("event flagged before stable");

    // rising sense flags a comparator rise
    a_rise_trip_flags : assert property (
        @(posedge hclk) disable iff (!hresetn)
        (stable && ctrl_r.detector_enable && ctrl_r.trip_direction_select
         && $past(ctrl_r.trip_direction_select) && $rose(comp_sync))
        |=> status_r[0])
        else $error("rising trip not flagged");

    // falling sense flags a comparator fall
    a_fall_trip_flags : assert property (
        @(posedge hclk) disable iff (!hresetn)
        (stable && ctrl_r.detector_enable && !ctrl_r.trip_direction_select
         && !$past(ctrl_r.trip_direction_select) && $fell(comp_sync))
        |=> status_r[0])
        else $error("falling trip not flagged");

    // rising sense ignores a comparator fall
    a_wrong_sense_quiet : assert property (
        @(posedge hclk) disable iff (!hresetn)
        (ctrl_r.trip_direction_select && $past(ctrl_r.trip_direction_select)
         && $fell(comp_sync) && !status_r[0])
        |=> !status_r[0])
        else $error("fall flagged in rising sense");

    // switching off never raises the flag
    a_no_flag_disabled : assert property (
        @(posedge hclk) disable iff (!hresetn)
        !ctrl_r.detector_enable
        |=> !$rose(status_r[0]))
        else $error("event flagged while detector off");

    // flag holds until a status read
    a_flag_sticky : assert property (
        @(posedge hclk) disable iff (!hresetn)
        (status_r[0] && !stat_rd)
        |=> status_r[0])
        else $error("event flag dropped without a read");

    // ------------------------------------------------------------------
    // main scenarios reached
    // ------------------------------------------------------------------
    c_stable_reached : cover property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(stable));

    c_rise_event : cover property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(status_r[0]) && ctrl_r.trip_direction_select);

    c_status_cleared : cover property (
        @(posedge hclk) disable iff (!hresetn)
        stat_rd && status_r[0]);

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (haddr[11:0])
            svdc_pkg::ADDR_CONTROL: begin
                rdata_nxt[svdc_pkg::POS_DIR]    = ctrl_r.trip_direction_select;
                rdata_nxt[svdc_pkg::POS_STABLE] = stable;
                rdata_nxt[svdc_pkg::POS_EN]     = ctrl_r.detector_enable;
                rdata_nxt[3:0]                  = ctrl_r.trip_level_select;
            end
            svdc_pkg::ADDR_STATUS: rdata_nxt[1:0] = status_r;
            svdc_pkg::ADDR_MASK:   rdata_nxt[1:0] = mask_r;
            svdc_pkg::ADDR_PINS:   rdata_nxt[1:0] = {stable, comp_sync};
            default:               rdata_nxt = 32'h0000_0000;
        endcase
    end

    // registered read data, updated at address phase acceptance
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_take) begin
            hrdata <= rdata_nxt;  // stands through the data phase
        end
    end
endmodule : svdc_top

/* File: verification/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic        hclk, hresetn, hsel, hwrite, comp_out;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout, hresp, detector_on, ext_input_route, direction_rise, irq;
    logic [3:0]  tap_select;
    int          n_fail, n_tests;

    // device under test, bus ready looped from its own hreadyout
    svdc_top i_svdc_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .comp_out(comp_out),
        .detector_on(detector_on), .ext_input_route(ext_input_route),
        .tap_select(tap_select), .direction_rise(direction_rise), .irq(irq)
    );

    // 25 MHz clock
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // compare and count
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one ahb-lite single word transfer, read data lands in rd
    task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {20'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        // read data taken at the edge that ends the data phase
        rd = hrdata;
    endtask : bus

    // idle cycles
    task cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask : cyc

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    // reset values and idle outputs
    task t_reset;
        bus(1'b0, svdc_pkg::ADDR_CONTROL, 32'h0);
        chk("control", 32'h0, rd);
        bus(1'b0, svdc_pkg::ADDR_MASK, 32'h0);
        chk("mask", 32'h0, rd);
        chk("irq", 32'h0, {31'h0, irq});
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : t_reset

    // every level code with the detector off
    task t_levels;
        logic [31:0] v;
        for (int l = 0; l < 16; l++) begin
            v = {24'h0, l[0], 3'h0, 4'(l)};
            bus(1'b1, svdc_pkg::ADDR_CONTROL, v);
            cyc(2);
            chk("tap", {28'h0, 4'(l)}, {28'h0, tap_select});
            chk("ext_route", {31'h0, l == 15}, {31'h0, ext_input_route});
            chk("dir", {31'h0, l[0]}, {31'h0, direction_rise});
            chk("on", 32'h0, {31'h0, detector_on});
            bus(1'b0, svdc_pkg::ADDR_CONTROL, 32'h0);
            chk("control rb", v, rd);
        end
    endtask : t_levels

    // enable with supply already low: nothing until stable
    task t_settle;
        comp_out <= 1'b0;
        bus(1'b1, svdc_pkg::ADDR_MASK, 32'h1);
        bus(1'b1, svdc_pkg::ADDR_CONTROL, 32'h13);
        cyc(2);
        chk("on", 32'h1, {31'h0, detector_on});
        cyc(20);
        bus(1'b0, svdc_pkg::ADDR_CONTROL, 32'h0);
        chk("stable early", 32'h13, rd);
        bus(1'b0, svdc_pkg::ADDR_STATUS, 32'h0);
        chk("flag early", 32'h0, rd);
        chk("irq early", 32'h0, {31'h0, irq});
        cyc(svdc_pkg::SETTLE_CYCLES);
        bus(1'b0, svdc_pkg::ADDR_CONTROL, 32'h0);
        chk("stable", 32'h33, rd);
        chk("irq", 32'h1, {31'h0, irq});
        comp_out <= 1'b1;
        cyc(10);
        chk("irq held", 32'h1, {31'h0, irq});
        bus(1'b0, svdc_pkg::ADDR_PINS, 32'h0);
        chk("live", 32'h3, rd);
        bus(1'b0, svdc_pkg::ADDR_STATUS, 32'h0);
        chk("status", 32'h3, rd);
        cyc(3);
        chk("irq clear", 32'h0, {31'h0, irq});
        bus(1'b0, svdc_pkg::ADDR_STATUS, 32'h0);
        chk("status clear", 32'h0, rd);
    endtask : t_settle

    // rising direction trips on rise only
    task t_rise;
        comp_out <= 1'b0;
        cyc(5);
        bus(1'b1, svdc_pkg::ADDR_CONTROL, 32'h94);
        bus(1'b0, svdc_pkg::ADDR_STATUS, 32'h0);
        comp_out <= 1'b1;
        cyc(6);
        bus(1'b0, svdc_pkg::ADDR_STATUS, 32'h0);
        chk("rise trip", 32'h1, rd);
        comp_out <= 1'b0;
        cyc(6);
        bus(1'b0, svdc_pkg::ADDR_STATUS, 32'h0);
        chk("fall ignored", 32'h0, rd);
    endtask : t_rise

    // disable, comparator activity ignored, unmapped place
    task t_off;
        bus(1'b1, svdc_pkg::ADDR_CONTROL, 32'h04);
        comp_out <= 1'b1;
        cyc(6);
        comp_out <= 1'b0;
        cyc(6);
        bus(1'b0, svdc_pkg::ADDR_STATUS, 32'h0);
        chk("off status", 32'h0, rd);
        chk("off", 32'h0, {31'h0, detector_on});
        bus(1'b0, svdc_pkg::ADDR_CONTROL, 32'h0);
        chk("off stable", 32'h04, rd);
        bus(1'b1, 12'h010, 32'hFF);
        bus(1'b0, 12'h010, 32'h0);
        chk("unmapped", 32'h0, rd);
        bus(1'b0, svdc_pkg::ADDR_MASK, 32'h0);
        chk("mask rb", 32'h1, rd);
    endtask : t_off

    // ------------------------------------------------------------------
    // verdict
    // ------------------------------------------------------------------
    task results;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    // main sequence
    initial begin
        n_fail   = 0;
        n_tests  = 0;
        hresetn  = 1'b0;
        hsel     = 1'b0;
        haddr    = 32'h0;
        htrans   = 2'h0;
        hwrite   = 1'b0;
        hsize    = 3'h2;
        hwdata   = 32'h0;
        comp_out = 1'b1;
        cyc(12);
        hresetn <= 1'b1;
        t_reset;
        t_levels;
        t_settle;
        t_rise;
        t_off;
        results;
    end

    // watchdog, run needs under a thousand cycles
    initial begin
        cyc(20000);
        n_fail++;
        $display("ERROR watchdog expected done seen hang");
        results;
    end
endmodule : tb_top
